// ==== hdl/flt_fault_timer.sv ====
`timescale 1ns/100ps
// Functional notes
// - The timer starts running as soon as the peak current limit is reached (overload).
// - Above the open-loop level the timer runs four times faster, a quarter of the duration.
// - Leaving the fault region before completion clears the timer to zero.
// - Without a power-limit offset, overload is flagged at the nominal peak-limit threshold.
// - With an offset, the overload threshold drops to four times (base limit plus offset).
// - On completion the device enters hiccup or latches off, as the version selects.
// - On completion all driver pulses stop immediately.
// - Moving between short circuit and overload keeps the count and only changes the rate.
// - At start-up a saturated feedback counts at short-circuit rate; regulation clears it.
// - The overload duration comes from the setting resistor, 500 ms for the typical value.
// - A grounded setting pin gives the reduced 125 ms duration.
// - An open or grounded setting pin falls back to a fixed known duration.
module flt_fault_timer
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire flt_pkg::flt_fb_t     feedbackCmp,
	input  wire flt_pkg::flt_set_t    settingDiag,
	input  wire logic [31:0]          settingTerminal,
	input  wire logic                 latchVersion,
	input  wire logic                 recoverRestart,
	output logic                      driverEnable,
	output logic                      faultTrip,
	output logic                      latchedOff,
	output logic                      timerRunning
);

	// Comparator and pin inputs arrive asynchronously; two flops before any use.
	// Only the second flop of each pair is read, so a metastable first stage
	// never reaches the timer logic. The price is a lag of two cycles, which
	// is far below the default and grounded-pin timer durations of this block.
	flt_pkg::flt_fb_t  fbMeta;
	flt_pkg::flt_fb_t  fbSync;
	flt_pkg::flt_set_t setMeta;
	flt_pkg::flt_set_t setSync;
	logic              verMeta;
	logic              verSync;
	logic              rstrMeta;
	logic              rstrSync;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fbMeta   <= '0;
			fbSync   <= '0;
			setMeta  <= '0;
			setSync  <= '0;
			verMeta  <= 1'b0;
			verSync  <= 1'b0;
			rstrMeta <= 1'b0;
			rstrSync <= 1'b0;
		end
		else
		begin
			fbMeta   <= feedbackCmp;
			fbSync   <= fbMeta;
			setMeta  <= settingDiag;
			setSync  <= setMeta;
			verMeta  <= latchVersion;
			verSync  <= verMeta;
			rstrMeta <= recoverRestart;
			rstrSync <= rstrMeta;
		end
	end

	// The setting word is quasi-static but still comes from outside the clock domain.
	// Each bit passes two flops; a third copy lets a new word be taken only once it has
	// read the same on two edges, so a word caught in mid-change is never used.
	logic [31:0] termMeta;
	logic [31:0] termSync;
	logic [31:0] termLast;
	logic [31:0] termHeld;
	logic [31:0] next_termHeld;

	// Accept the synchronised word only when it is steady
	always_comb
	begin
		if (termSync == termLast)
			next_termHeld = termSync;
		else
			next_termHeld = termHeld;
	end

	// Setting word synchroniser and holding register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			termMeta <= flt_pkg::ZERO_ACC;
			termSync <= flt_pkg::ZERO_ACC;
			termLast <= flt_pkg::ZERO_ACC;
			termHeld <= flt_pkg::ZERO_ACC;
		end
		else
		begin
			termMeta <= settingTerminal;
			termSync <= termMeta;
			termLast <= termSync;
			termHeld <= next_termHeld;
		end
	end

	// Terminal count. A grounded pin gives a quarter of the default overload time, an open
	// pin the full default; either way the timer never runs on an undefined setting.
	// A zero word means no resistor setting was delivered, so the default applies too.
	logic [31:0] terminal;
	always_comb
	begin
		if (setSync.settingGnd)
			terminal = flt_pkg::GND_TERMINAL;
		else if (setSync.settingOpen)
			terminal = flt_pkg::FULL_TERMINAL;
		else if (termHeld == flt_pkg::ZERO_ACC)
			terminal = flt_pkg::FULL_TERMINAL;
		else
			terminal = termHeld;
	end

	flt_pkg::flt_state_t state;
	flt_pkg::flt_state_t next_state;
	logic [31:0]         acc;
	logic [31:0]         next_acc;
	logic                next_driverEnable;
	logic                next_faultTrip;
	logic                next_latchedOff;
	logic                next_timerRunning;

	// Threshold choice (nominal or offset-lowered) is done by the comparator,
	// so overloadState already reflects it.
	// One accumulator serves both fault levels: only the step changes, so a
	// move between the two levels keeps the time already spent in fault.
	// The sum is one bit wider than the accumulator so that a setting near
	// the top of the word cannot wrap round and postpone the trip.
	// Any cycle outside the fault region clears the accumulator at once,
	// which is what lets a transient overload pass without a trip.
	always_comb
	begin
		logic        inFault;
		logic [31:0] step;
		logic [32:0] sum;
		inFault           = fbSync.overloadState | fbSync.shortCircuitState;
		step              = fbSync.shortCircuitState ? flt_pkg::STEP_FAST : flt_pkg::STEP_SLOW;
		sum               = {1'b0, acc} + {1'b0, step};
		next_state        = state;
		next_acc          = acc;
		next_faultTrip    = 1'b0;
		next_driverEnable = driverEnable;
		next_latchedOff   = latchedOff;
		next_timerRunning = 1'b0;
		case (state)
			flt_pkg::ST_RUN:
			begin
				// Pulses are allowed in this state; a start-up with saturated
				// feedback counts here at the fast rate like any short circuit
				next_driverEnable = 1'b1;
				if (!inFault)
					next_acc = flt_pkg::ZERO_ACC;
				else if (sum[31:0] >= terminal || sum[32])
				begin
					// Saturating compare stops any wrap from hiding a trip.
					// Pulses stop on the very edge that registers the trip, and the
					// accumulator is cleared so a restart begins from zero.
					next_acc          = flt_pkg::ZERO_ACC;
					next_faultTrip    = 1'b1;
					next_driverEnable = 1'b0;
					next_state        = verSync ? flt_pkg::ST_LATCHED : flt_pkg::ST_HICCUP;
					next_latchedOff   = verSync;
				end
				else
				begin
					next_acc          = sum[31:0];
					next_timerRunning = 1'b1;
				end
			end
			flt_pkg::ST_HICCUP:
			begin
				// Auto-recovery waits for the supply sequencer's restart request;
				// the comparators are ignored here, so no count builds up meanwhile
				next_driverEnable = 1'b0;
				if (rstrSync)
					next_state = flt_pkg::ST_RUN;
			end
			flt_pkg::ST_LATCHED:
			begin
				// Only a full reset leaves this state, like a mains disconnect;
				// the restart request has no effect once latched
				next_driverEnable = 1'b0;
				next_latchedOff   = 1'b1;
			end
			default:
			begin
				// An illegal state code is treated as a fault: the safe choice
				// for a power stage is to keep the driver off
				next_state        = flt_pkg::ST_LATCHED;
				next_driverEnable = 1'b0;
			end
		endcase
	end

	// Timer and protection state. Every output is a flop, so the driver
	// enable seen outside never glitches while the next state settles.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state        <= flt_pkg::ST_RUN;
			acc          <= flt_pkg::ZERO_ACC;
			driverEnable <= 1'b0;
			faultTrip    <= 1'b0;
			latchedOff   <= 1'b0;
			timerRunning <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			acc          <= next_acc;
			driverEnable <= next_driverEnable;
			faultTrip    <= next_faultTrip;
			latchedOff   <= next_latchedOff;
			timerRunning <= next_timerRunning;
		end
	end

endmodule

// ==== hdl/flt_pkg.sv ====
package flt_pkg;
	// Clock rate and timer figures
	localparam int unsigned CLK_HZ            = 250000000;
	localparam int unsigned FULL_TIME_MS      = 500;
	localparam int unsigned GND_TIME_MS       = 125;
	localparam int unsigned FAST_RATE         = 4;
	localparam int unsigned SLOW_RATE         = 1;
	// Cycles of the full overload duration at the rate of one step per cycle
	localparam longint unsigned FULL_CYCLES   = longint'(CLK_HZ) / 1000 * FULL_TIME_MS;
	localparam int unsigned ACC_W             = 32;
	localparam logic [31:0] FULL_TERMINAL     = 32'(FULL_CYCLES);
	// Grounded setting pin: the overload duration drops to a quarter of the default
	localparam logic [31:0] GND_TERMINAL      = 32'(longint'(CLK_HZ) / 1000 * GND_TIME_MS);
	localparam logic [31:0] ZERO_ACC          = 32'h0000_0000;
	localparam logic [31:0] STEP_SLOW         = 32'(SLOW_RATE);
	localparam logic [31:0] STEP_FAST         = 32'(FAST_RATE);

	// Feedback comparator decisions from the analog front end
	typedef struct packed {
		logic overloadState;
		logic shortCircuitState;
	} flt_fb_t;

	// Timer-setting pin diagnosis
	typedef struct packed {
		logic settingOpen;
		logic settingGnd;
	} flt_set_t;

	typedef enum logic [1:0] {ST_RUN, ST_HICCUP, ST_LATCHED} flt_state_t;
endpackage

// ==== verification/flt_fault_timer_props.sv ====
`timescale 1ns/100ps
module flt_fault_timer_props
(
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire flt_pkg::flt_fb_t  feedbackCmp,
	input wire flt_pkg::flt_set_t settingDiag,
	input wire logic [31:0]       settingTerminal,
	input wire logic              latchVersion,
	input wire logic              recoverRestart,
	input wire logic              driverEnable,
	input wire logic              faultTrip,
	input wire logic              latchedOff,
	input wire logic              timerRunning
);
	// Either comparator bit puts the feedback in the fault region
	wire logic inFault = feedbackCmp.overloadState | feedbackCmp.shortCircuitState;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_start; $rose(inFault) && driverEnable |-> ##3 timerRunning; endproperty
	a_start: assert property (p_start) else $error("timer did not start");
	property p_cause; timerRunning |-> $past(inFault, 3); endproperty
	a_cause: assert property (p_cause) else $error("timer ran outside fault");
	property p_pulse; faultTrip |=> !faultTrip; endproperty
	a_pulse: assert property (p_pulse) else $error("trip longer than one cycle");
	property p_stop; faultTrip |-> !driverEnable ##1 !driverEnable; endproperty
	a_stop: assert property (p_stop) else $error("pulses not stopped");
	property p_mode; faultTrip |-> latchedOff == $past(latchVersion, 3); endproperty
	a_mode: assert property (p_mode) else $error("wrong end state");
	property p_hold; latchedOff |=> latchedOff && !driverEnable; endproperty
	a_hold: assert property (p_hold) else $error("latch released");
	property p_idle; !driverEnable && !faultTrip |-> !timerRunning; endproperty
	a_idle: assert property (p_idle) else $error("timer ran while stopped");
	property p_ended; faultTrip |-> $past(timerRunning); endproperty
	a_ended: assert property (p_ended) else $error("trip without count");
endmodule
bind flt_fault_timer flt_fault_timer_props u_props (.*);

// ==== verification/flt_cmp_model.sv ====
`timescale 1ns/100ps
module flt_cmp_model
(
	input  var int           fbMv,
	input  var int           offsetMv,
	output flt_pkg::flt_fb_t cmp
);
	// Offset lowers only the overload level; the open-loop level stays fixed
	always_comb
	begin
		cmp.overloadState = fbMv >= (800 + offsetMv) * 4;
		cmp.shortCircuitState = fbMv > 4100;
	end
endmodule

// ==== verification/tb_flt_fault_timer.sv ====
`timescale 1ns/100ps
module tb_flt_fault_timer;
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [31:0]       settingTerminal = 32'h0000_0028;
	logic              latchVersion = 1'b0;
	logic              recoverRestart = 1'b0;
	logic              driverEnable, faultTrip, latchedOff, timerRunning;
	flt_pkg::flt_set_t settingDiag = 2'h0;
	flt_pkg::flt_fb_t  feedbackCmp;
	int                fbMv = 2000, offsetMv = 0, cyc = 0, err_count = 0, compares = 0;
	logic [31:0]       expQ[$];
	flt_fault_timer u_flt_fault_timer (.*);
	flt_cmp_model u_flt_cmp_model (.fbMv, .offsetMv, .cmp(feedbackCmp));
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		compares++;
		if (seen !== want)
		begin
			err_count++;
			$display("BAD %s exp %0d seen %0d", what, want, seen);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Short circuit for fastCyc cycles, then overload; the trip edge is noted first
	task automatic episode(input int fastCyc, input int loadMv);
		int t;
		t = int'(settingTerminal);
		expQ.push_back(32'(cyc + 2 + ((t <= 4 * fastCyc) ? (t + 3) / 4 : t - 3 * fastCyc)));
		if (fastCyc > 0)
		begin
			fbMv = 4500;
			repeat (fastCyc) @(negedge sys_clk);
		end
		fbMv = loadMv;
		for (t = 0; t < 1000 && driverEnable === 1'b1; t++) @(negedge sys_clk);
		if (t == 1000)
		begin
			err_count++;
			complete_run();
		end
		fbMv = 2000;
		check(32'(latchedOff), 32'(latchVersion), "latch");
	endtask
	// Each trip takes the oldest noted trip edge
	always @(negedge sys_clk)
		if (faultTrip === 1'b1)
			check(32'(cyc), expQ.size() ? expQ.pop_front() : 32'h0, "trip");
	initial
	begin
		void'($urandom(32'hb320));
		repeat (20) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		// A diagnosed setting pin ignores the small word and uses a long default
		for (int i = 1; i < 3; i++)
		begin
			settingDiag = 2'(i);
			fbMv = 3300;
			repeat (100) @(negedge sys_clk);
			check(32'(driverEnable), 32'h1, "diag");
			fbMv = 2000;
			settingDiag = 2'h0;
			repeat (5) @(negedge sys_clk);
		end
		for (int i = 0; i < 6; i++)
		begin
			settingTerminal = 32'($urandom_range(60, 20));
			latchVersion = 1'(i == 5);
			offsetMv = (i % 2) ? -200 : 0;
			// Partial overload that must be cleared before the real fault
			fbMv = 3300;
			repeat (settingTerminal - 5) @(negedge sys_clk);
			check(32'(timerRunning), 32'h1, "run");
			fbMv = 2000;
			repeat (5) @(negedge sys_clk);
			check(32'(timerRunning), 32'h0, "run");
			episode(i == 1 ? 99 : i * 3, (i % 2 ? 2400 : 3200) + $urandom_range(800, 0));
			recoverRestart = 1'b1;
			repeat (5) @(negedge sys_clk);
			recoverRestart = 1'b0;
			check(32'(driverEnable), 32'(!latchVersion), "drive");
		end
		complete_run();
	end
endmodule
